// ==== hdl/rcm_consts.vh ====
// Constants for the regulator clock manager: register map, fields, timing.
// Assumes a 25 MHz system clock that stands in for the 100 kHz logic clock.
`ifndef RCM_CONSTS_VH
`define RCM_CONSTS_VH
`define RCM_CLK_HZ 25000000
`define RCM_STEP_NS 5200
`define RCM_STEP_CYC ((`RCM_STEP_NS * 25 + 999) / 1000)
`define RCM_MOD_HZ 24000
`define RCM_MOD_HALF_CYC (`RCM_CLK_HZ / (`RCM_MOD_HZ * 2))
`define RCM_WIN_CYC 25000
`define RCM_BAND0_MIN 16'd2000
`define RCM_BAND0_MAX 16'd3000
`define RCM_BAND1_MIN 16'd333
`define RCM_BAND1_MAX 16'd500
`define RCM_HF_DIV 8
`define RCM_ADR_CTRL 4'h0
`define RCM_ADR_STAT 4'h1
`define RCM_ADR_FLAG 4'h2
`define RCM_ADR_MASK 4'h3
`define RCM_CTRL_TUNE_LSB 0
`define RCM_CTRL_SPREN 4
`define RCM_CTRL_SPRW 5
`define RCM_CTRL_BAND 6
`define RCM_CTRL_EXPEN 7
`define RCM_FLAG_SETTLED 0
`define RCM_FLAG_FAULT 1
`define RCM_MASK_RST 2'h0
`endif

// ==== hdl/rcm_freq_meter.v ====
// Edge counter that measures an input clock over a fixed window.
// Assumes the input is already synchronised to clk.
`timescale 1ns/1ns
`include "rcm_consts.vh"
module rcm_freq_meter #(
  parameter WIN_CYC = `RCM_WIN_CYC
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Measured input and band
  input wire sigSync,
  input wire bandSel,
  // Result
  output reg valid_reg
);
  reg [31:0] winCnt_reg;
  reg [15:0] edgeCnt_reg;
  reg prev_reg;
  wire rise = sigSync & ~prev_reg;
  wire winEnd = (winCnt_reg == WIN_CYC - 1);
  // Window of 1 ms counts edges in kHz directly
  wire [15:0] lo = bandSel ? `RCM_BAND1_MIN : `RCM_BAND0_MIN;
  wire [15:0] hi = bandSel ? `RCM_BAND1_MAX : `RCM_BAND0_MAX;
  wire [15:0] total = edgeCnt_reg + {15'h0000, rise};

  always @(posedge clk) begin
    if (!nrst) begin
      winCnt_reg <= 32'h00000000;
      edgeCnt_reg <= 16'h0000;
      prev_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      prev_reg <= sigSync;
      if (winEnd) begin
        winCnt_reg <= 32'h00000000;
        edgeCnt_reg <= 16'h0000;
        valid_reg <= (total >= lo) && (total <= hi);
      end else begin
        winCnt_reg <= winCnt_reg + 32'h00000001;
        if (rise && edgeCnt_reg != 16'hffff)
          edgeCnt_reg <= total;
      end
    end
  end
endmodule

// ==== hdl/rcm_clock_manager.v ====
// Regulator clock manager: tuning walk, spread, sync check, export, irq.
// Assumes a classic Wishbone master and OTP defaults stable during reset.
`timescale 1ns/1ns
`include "rcm_consts.vh"
module rcm_clock_manager #(
  parameter WIN_CYC = `RCM_WIN_CYC
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // OTP defaults
  input wire [3:0] otpTuningCode,
  input wire otpSpreadEnable,
  input wire otpSpreadWidth,
  input wire otpBandSelect,
  input wire otpSyncMode,
  input wire clock_export_default,
  // Sync pin
  input wire syncPinIn,
  output reg syncPinOut,
  output reg syncPinOe,
  output reg syncPullDown,
  // Analog controls
  output reg [3:0] hfTuneApplied,
  output reg pllEnable,
  output reg pllSrcExternal,
  output reg spreadActive,
  output reg spreadUp,
  output reg swClkEnable,
  // Interrupt
  output reg irq_out_n
);
  reg [3:0] hf_clock_tuning_code_reg;
  reg spread_enable_reg;
  reg spread_width_select_reg;
  reg input_band_select_reg;
  reg clock_export_enable_reg;
  reg syncMode_reg;
  reg [3:0] curTune_reg;
  reg [7:0] stepCnt_reg;
  reg walking_reg;
  reg freq_settled_irq_reg;
  reg ext_clock_fault_irq_reg;
  reg [1:0] mask_reg;
  reg useExt_reg;
  reg [9:0] modCnt_reg;
  reg [2:0] divCnt_reg;
  reg sync1_reg;
  reg sync2_reg;
  reg loaded_reg;
  wire extValid;
  // Live fault sense: high whenever the last window was out of band
  wire ext_clock_fault_live = ~extValid;

  // The pin is asynchronous to clk; only the second flop feeds logic, the
  // first is allowed to go metastable. The meter needs no further stages.
  // Two-flop synchroniser on the sync pin
  always @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= syncPinIn;
      sync2_reg <= sync1_reg;
    end
  end

  // The meter's verdict changes only at window ends, so a fault is seen at
  // most two windows after the input stops or leaves its band.
  // input frequency check
  rcm_freq_meter #(.WIN_CYC(WIN_CYC)) uMeter (
    .clk(clk),
    .nrst(nrst),
    .sigSync(sync2_reg),
    .bandSel(input_band_select_reg),
    .valid_reg(extValid)
  );

  // The code space is not monotonic in frequency: codes 9 to c sit below
  // code 0. Walking in code order would jump across the band, so the walk
  // runs on ranks, where rank 0 is the lowest and rank 8 the highest step.
  // Both helpers are only ever given legal codes or in-range ranks; an
  // unused code 5 to 8 would map to a rank past the end and codes d to f
  // would alias ranks 4 to 6, which is why writes of such codes are
  // dropped before they reach the target register.
  // Map tuning code to a linear rank so the walk passes every step
  function [3:0] rankOf;
    input [3:0] code;
    begin
      if (code >= 4'h9)
        rankOf = code - 4'h9;
      else
        rankOf = code + 4'h4;
    end
  endfunction
  function [3:0] codeOf;
    input [3:0] rank;
    begin
      if (rank < 4'h4)
        codeOf = rank + 4'h9;
      else
        codeOf = rank - 4'h4;
    end
  endfunction
  function isLegal;
    input [3:0] code;
    begin
      isLegal = (code <= 4'h4) || (code >= 4'h9 && code <= 4'hc);
    end
  endfunction

  // Register map, one word per index, low byte only:
  //   index 0 control: tuning code, spread on, spread width, band, export on
  //   index 1 status, read only: current code, live fault, spread, external, sync
  //   index 2 flags: settled and fault, a written one clears
  //   index 3 masks: a one keeps the matching flag off the irq pin
  // Writes to the status index or to unmapped indices are acknowledged and lost,
  // so software that probes the map never stalls the bus.
  // Only byte lane zero carries fields; the other lanes are ignored on purpose.
  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wrCtrl = busReq & wb_we_i & (wb_adr_i == `RCM_ADR_CTRL) & wb_sel_i[0];
  wire wrFlag = busReq & wb_we_i & (wb_adr_i == `RCM_ADR_FLAG) & wb_sel_i[0];
  wire wrMask = busReq & wb_we_i & (wb_adr_i == `RCM_ADR_MASK) & wb_sel_i[0];
  wire [3:0] newTune = wb_dat_i[`RCM_CTRL_TUNE_LSB + 3:`RCM_CTRL_TUNE_LSB];
  // manual tuning blocked under spread or sync
  wire tuneLocked = spreadActive | syncMode_reg;
  wire spreadOn = spread_enable_reg & ~syncMode_reg;
  wire atTarget = (curTune_reg == hf_clock_tuning_code_reg);
  wire [3:0] curRank = rankOf(curTune_reg);
  wire [3:0] tgtRank = rankOf(hf_clock_tuning_code_reg);
  wire stepDone = (stepCnt_reg == `RCM_STEP_CYC - 1);

  // OTP values are taken once, on the first cycle after reset, so they need
  // only be stable across the reset release. Sync mode has no register bit:
  // it is fixed for the whole run and only a reset can change it.
  // An unused OTP tuning code falls back to code 0, the nominal frequency.
  // Control registers, OTP load at reset release
  always @(posedge clk) begin
    if (!nrst) begin
      loaded_reg <= 1'b0;
      hf_clock_tuning_code_reg <= 4'h0;
      spread_enable_reg <= 1'b0;
      spread_width_select_reg <= 1'b0;
      input_band_select_reg <= 1'b0;
      clock_export_enable_reg <= 1'b0;
      syncMode_reg <= 1'b0;
      mask_reg <= `RCM_MASK_RST;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      hf_clock_tuning_code_reg <= isLegal(otpTuningCode) ? otpTuningCode : 4'h0;
      spread_enable_reg <= otpSpreadEnable;
      spread_width_select_reg <= otpSpreadWidth;
      input_band_select_reg <= otpBandSelect;
      clock_export_enable_reg <= clock_export_default;
      syncMode_reg <= otpSyncMode;
    end else begin
      if (wrCtrl) begin
        if (isLegal(newTune) && !tuneLocked)
          hf_clock_tuning_code_reg <= newTune;
        spread_enable_reg <= wb_dat_i[`RCM_CTRL_SPREN];
        spread_width_select_reg <= wb_dat_i[`RCM_CTRL_SPRW];
        input_band_select_reg <= wb_dat_i[`RCM_CTRL_BAND];
        clock_export_enable_reg <= wb_dat_i[`RCM_CTRL_EXPEN];
      end
      if (wrMask)
        mask_reg <= wb_dat_i[1:0];
    end
  end

  // The hold counter restarts on every step, so each intermediate code
  // stands for the full hold time before the next one is applied. A new
  // target written mid-walk takes effect from the current code onwards;
  // the walk never jumps back to where it started. A write that lands on
  // the current code while idle starts no walk and so raises no settled flag.
  // step walk with hold time
  always @(posedge clk) begin
    if (!nrst) begin
      curTune_reg <= 4'h0;
      stepCnt_reg <= 8'h00;
      walking_reg <= 1'b0;
    end else if (!loaded_reg) begin
      curTune_reg <= isLegal(otpTuningCode) ? otpTuningCode : 4'h0;
      walking_reg <= 1'b0;
    end else if (!atTarget) begin
      walking_reg <= 1'b1;
      if (stepDone) begin
        stepCnt_reg <= 8'h00;
        curTune_reg <= (tgtRank > curRank) ? codeOf(curRank + 4'h1) : codeOf(curRank - 4'h1);
      end else begin
        stepCnt_reg <= stepCnt_reg + 8'h01;
      end
    end else begin
      stepCnt_reg <= 8'h00;
      walking_reg <= 1'b0;
    end
  end

  // Both flags are sticky. The fault flag is refreshed every cycle while the
  // input stays bad, so software cannot clear it until the input recovers;
  // that is what keeps the return to the external clock from chattering.
  // Flags: hardware set wins over software write-one-to-clear
  always @(posedge clk) begin
    if (!nrst) begin
      freq_settled_irq_reg <= 1'b0;
      ext_clock_fault_irq_reg <= 1'b0;
    end else begin
      if (walking_reg && atTarget)
        freq_settled_irq_reg <= 1'b1;
      else if (wrFlag && wb_dat_i[`RCM_FLAG_SETTLED])
        freq_settled_irq_reg <= 1'b0;
      if (syncMode_reg && ext_clock_fault_live && loaded_reg)
        ext_clock_fault_irq_reg <= 1'b1;
      else if (wrFlag && wb_dat_i[`RCM_FLAG_FAULT])
        ext_clock_fault_irq_reg <= 1'b0;
    end
  end

  // Dropping to the internal source is immediate on a bad window, while the
  // way back waits for software: a flaky input is never re-selected alone.
  // The PLL source follows one cycle later, always from a settled select.
  // Source select and PLL control
  always @(posedge clk) begin
    if (!nrst) begin
      useExt_reg <= 1'b0;
      pllEnable <= 1'b0;
      pllSrcExternal <= 1'b0;
    end else begin
      // PLL always on when sync enabled
      pllEnable <= syncMode_reg;
      if (!syncMode_reg || ext_clock_fault_live)
        useExt_reg <= 1'b0;
      else if (!ext_clock_fault_irq_reg && extValid)
        useExt_reg <= 1'b1;
      pllSrcExternal <= useExt_reg;
    end
  end

  // The modulation counter is held in reset while spread is off, so every
  // spread episode starts from the same phase. Half period is clk/48000,
  // 520 cycles, which is why the counter needs ten bits.
  // 24 kHz spread modulation, triangle direction toggles each half period
  always @(posedge clk) begin
    if (!nrst) begin
      modCnt_reg <= 10'h000;
      spreadUp <= 1'b0;
      spreadActive <= 1'b0;
    end else begin
      spreadActive <= spreadOn & ~useExt_reg;
      if (!spreadActive) begin
        modCnt_reg <= 10'h000;
        spreadUp <= 1'b0;
      end else if (modCnt_reg == `RCM_MOD_HALF_CYC - 1) begin
        modCnt_reg <= 10'h000;
        spreadUp <= ~spreadUp;
      end else begin
        modCnt_reg <= modCnt_reg + 10'h001;
      end
    end
  end

  // The divider free-runs from reset; only the pulse is gated when the
  // external source is in use, so the pin export keeps its phase.
  // divide by eight enable for switching clock
  always @(posedge clk) begin
    if (!nrst) begin
      divCnt_reg <= 3'h0;
      swClkEnable <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_reg + 3'h1;
      swClkEnable <= (divCnt_reg == `RCM_HF_DIV - 1) & ~useExt_reg;
    end
  end

  // Pull-down and output enable are exact complements: the pin is never
  // both driven and pulled, and never left floating while exporting is off.
  // The exported clock is the divider's top bit, a square wave at clk/8.
  // Sync pin drive and applied tuning
  always @(posedge clk) begin
    if (!nrst) begin
      syncPinOut <= 1'b0;
      syncPinOe <= 1'b0;
      syncPullDown <= 1'b1;
      hfTuneApplied <= 4'h0;
      irq_out_n <= 1'b1;
    end else begin
      hfTuneApplied <= curTune_reg;
      syncPinOe <= ~syncMode_reg & clock_export_enable_reg;
      syncPullDown <= ~(~syncMode_reg & clock_export_enable_reg);
      syncPinOut <= ~syncMode_reg & clock_export_enable_reg & divCnt_reg[2];
      // The irq pin is a level: it stays low while an unmasked flag is set,
      // and masking a set flag releases the pin without clearing the flag.
      // active-low irq unless masked
      irq_out_n <= ~((freq_settled_irq_reg & ~mask_reg[0]) |
                     (ext_clock_fault_irq_reg & ~mask_reg[1]));
    end
  end

  // A request is taken only while ack is low, so a master that holds its
  // strobe through the ack edge is never served twice. Read data is
  // registered with ack and then held, which keeps it valid at the ack edge.
  // Wishbone: one-cycle ack, unmapped reads zero
  always @(posedge clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        case (wb_adr_i)
          `RCM_ADR_CTRL: wb_dat_o <= {24'h000000, clock_export_enable_reg,
            input_band_select_reg, spread_width_select_reg, spread_enable_reg,
            hf_clock_tuning_code_reg};
          `RCM_ADR_STAT: wb_dat_o <= {24'h000000, syncMode_reg, useExt_reg,
            spreadActive, ext_clock_fault_live, curTune_reg};
          `RCM_ADR_FLAG: wb_dat_o <= {30'h00000000, ext_clock_fault_irq_reg,
            freq_settled_irq_reg};
          `RCM_ADR_MASK: wb_dat_o <= {30'h00000000, mask_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ==== dv/rcm_clock_manager_properties.sv ====
// Port-level checks for the regulator clock manager.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module rcm_clock_manager_properties #(
  parameter WIN_CYC = 25000
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Bus answer
  input wire wb_ack_o,
  // Clock controls
  input wire [3:0] hfTuneApplied,
  input wire pllEnable,
  input wire spreadActive,
  input wire swClkEnable,
  // Sync pin
  input wire syncPinOut,
  input wire syncPinOe,
  input wire syncPullDown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] holdCnt_reg;
  logic [3:0] prevTune_reg;
  // Cycles the applied code has stood; saturates so long idles never wrap
  always_ff @(posedge clk) begin
    prevTune_reg <= hfTuneApplied;
    if (!nrst || hfTuneApplied != prevTune_reg) holdCnt_reg <= 8'h00;
    else if (holdCnt_reg != 8'hff) holdCnt_reg <= holdCnt_reg + 8'h01;
  end
  // Pulse spacing and pin half period
  sequence s_quiet7;
    !swClkEnable [*7];
  endsequence
  sequence s_pin_held;
    ($stable(syncPinOut) || !syncPinOe) [*3];
  endsequence
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_pll_fixed: assert property ($past(nrst, 3) && $past(nrst, 2) && $past(nrst) |-> $stable(pllEnable))
    else $error("pll enable moved");
  chk_spread_forced: assert property (pllEnable |-> !spreadActive)
    else $error("spread active in sync mode");
  chk_sync_no_tune: assert property ($past(nrst, 3) && pllEnable |-> $stable(hfTuneApplied))
    else $error("tuning moved in sync mode");
  chk_code_legal: assert property (hfTuneApplied <= 4'h4 || hfTuneApplied inside {[4'h9:4'hc]})
    else $error("unused code applied");
  chk_step_hold: assert property ($past(nrst, 3) && hfTuneApplied != prevTune_reg |-> holdCnt_reg >= 8'd129)
    else $error("step held too short");
  chk_sw_divide: assert property (swClkEnable |=> s_quiet7)
    else $error("switching pulse too soon");
  chk_export_pin: assert property (syncPinOe |-> !syncPullDown && !pllEnable)
    else $error("export pin conflict");
  chk_export_rate: assert property (syncPinOe && $past(syncPinOe) && $changed(syncPinOut) |=> s_pin_held)
    else $error("export pin rate wrong");
endmodule
bind rcm_clock_manager rcm_clock_manager_properties #(.WIN_CYC(WIN_CYC)) i_props (
  .clk(clk), .nrst(nrst), .wb_ack_o(wb_ack_o), .hfTuneApplied(hfTuneApplied),
  .pllEnable(pllEnable), .spreadActive(spreadActive), .swClkEnable(swClkEnable),
  .syncPinOut(syncPinOut), .syncPinOe(syncPinOe), .syncPullDown(syncPullDown));

// ==== dv/rcm_sync_source.sv ====
// External clock source driving the sync pin.
// Assumes the bench resolves the pin with the device's output enable.
`timescale 1ns/1ns
module rcm_sync_source #(
  parameter int HALF_NS = 201
) (
  // Control
  input wire logic run,
  // Pin drive
  output logic level
);
  // equal half periods
  // Idles low so the pull-down level shows; odd half period keeps phase apart
  initial level = 1'b0;
  always begin
    #(HALF_NS);
    level = run ? ~level : 1'b0;
  end
endmodule

// ==== dv/rcm_clock_manager_bench.sv ====
// Directed bench for the regulator clock manager over classic Wishbone.
// Assumes the sync source model and the bound properties checker.
`timescale 1ns/1ns
module rcm_clock_manager_bench;
  logic clk, nrst, wbCyc, wbStb, wbWe, wbAck, otpSync, expDef, srcRun, srcLvl;
  logic pinOut, pinOe, pullDn, pllEn, pllExt, sprAct, sprUp, swClk, irqN;
  logic [3:0] wbAdr, otpTune, tune;
  logic [31:0] wbDatI, wbDatO, q;
  logic [3:0] steps[$];
  int fails, tests_run, n;
  // Device drive wins, else the source, which idles low
  wire syncPin = pinOe ? pinOut : srcLvl;

  rcm_clock_manager i_rcm_clock_manager (
    .clk(clk), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .otpTuningCode(otpTune), .otpSpreadEnable(1'b0),
    .otpSpreadWidth(1'b0), .otpBandSelect(1'b0), .otpSyncMode(otpSync),
    .clock_export_default(expDef), .syncPinIn(syncPin), .syncPinOut(pinOut),
    .syncPinOe(pinOe), .syncPullDown(pullDn), .hfTuneApplied(tune), .pllEnable(pllEn),
    .pllSrcExternal(pllExt), .spreadActive(sprAct), .spreadUp(sprUp),
    .swClkEnable(swClk), .irq_out_n(irqN));
  rcm_sync_source i_rcm_sync_source (.run(srcRun), .level(srcLvl));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Every move of the applied code
  always @(tune) steps.push_back(tune);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic cycle; ack is looked at mid-cycle, where it has settled, and
  // q holds the read data that stands at the rising edge where ack is high
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    @(negedge clk);
    while (wbAck !== 1'b1 && k < 50) begin
      k++;
      @(negedge clk);
    end
    q = wbDatO;
    @(posedge clk);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (k == 50) fails++;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic rst(input logic s, input logic x);
    otpSync <= s;
    expDef <= x;
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // Writes a code, then compares each step taken, first step lowest nibble
  task automatic walk(input logic [7:0] c, input int s, input logic [31:0] seq);
    repeat (130) @(posedge clk);
    steps.delete();
    xfer(1'b1, 4'h0, {24'h0, c});
    repeat (s * 130 + 20) @(posedge clk);
    chk(32'(steps.size()), 32'(s));
    for (int i = 0; i < s; i++) chk({28'h0, steps[i]}, {28'h0, seq[4*i +: 4]});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {nrst, wbCyc, wbStb, wbWe, srcRun} = 5'h0;
    wbAdr = 4'h0;
    wbDatI = 32'h0;
    otpTune = 4'h2;
    otpSync = 1'b0;
    expDef = 1'b1;
    fails = 0;
    tests_run = 0;
    rst(1'b0, 1'b1);
    rd(4'h0, 32'h82, 32'hff);
    rd(4'h1, 32'h02, 32'hef);
    rd(4'h3, 32'h0, 32'hff);
    rd(4'h7, 32'h0, 32'hffffffff);
    chk({30'h0, pinOe, pullDn}, 32'h2);
    $display("test defaults done");
    walk(8'h89, 6, 32'h009abc01);
    rd(4'h2, 32'h1, 32'hff);
    chk({31'h0, irqN}, 32'h0);
    xfer(1'b1, 4'h2, 32'h1);
    xfer(1'b1, 4'h3, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irqN}, 32'h1);
    walk(8'h80, 4, 32'h00000cba);
    chk({31'h0, irqN}, 32'h1);
    rd(4'h2, 32'h1, 32'hff);
    xfer(1'b1, 4'h2, 32'h1);
    $display("test tuning walk done");
    xfer(1'b1, 4'h0, 32'h85);
    rd(4'h0, 32'h80, 32'hff);
    xfer(1'b1, 4'h0, 32'h90);
    xfer(1'b1, 4'h0, 32'hb1);
    rd(4'h0, 32'hb0, 32'hff);
    rd(4'h1, 32'h20, 32'hef);
    xfer(1'b1, 4'h0, 32'h0);
    repeat (3) @(posedge clk);
    chk({29'h0, sprAct, pinOe, pullDn}, 32'h1);
    $display("test spread and export done");
    rst(1'b1, 1'b0);
    xfer(1'b1, 4'h0, 32'h13);
    rd(4'h1, 32'h92, 32'hff);
    rd(4'h2, 32'h2, 32'hff);
    chk({29'h0, pllEn, pllExt, irqN}, 32'h4);
    srcRun <= 1'b1;
    n = 0;
    q = 32'h10;
    while (q[4] && n < 2500) begin
      repeat (20) @(posedge clk);
      xfer(1'b0, 4'h1, 32'h0);
      n++;
    end
    chk(q & 32'h10, 32'h0);
    chk({31'h0, pllExt}, 32'h0);
    xfer(1'b1, 4'h2, 32'h2);
    repeat (3) @(posedge clk);
    rd(4'h1, 32'hc2, 32'hff);
    chk({30'h0, pllExt, irqN}, 32'h3);
    $display("test external sync done");
    end_of_test();
  end

  // Hang guard: past the longest sync poll plus the tuning tests
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule
